// ### verilog/nvmbw_pkg.sv
// shared constants and types for the nvm block write controller and its core end
package nvmbw_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int PROG_TIME_US = 2000;
  localparam int PWRT_TIME_US = 1000;
  localparam int PROG_CYCLES_DFLT = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int PWRT_CYCLES_DFLT = PWRT_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W = 24;

  // ----------------------------------------------------------------
  // memory geometry
  // ----------------------------------------------------------------
  localparam int BLK_AW = 3;
  localparam int BLK_BYTES = 8;
  localparam int FLASH_BYTES = 256;
  localparam int EE_BYTES = 256;
  localparam logic [7:0] FLASH_LAST_ADDR = 8'hEF;
  localparam logic [7:0] EE_LAST_ADDR = 8'hEF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ----------------------------------------------------------------
  // device register indices and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_UNLOCK = 4'h1;
  localparam logic [3:0] REG_ADDR = 4'h2;
  localparam logic [3:0] REG_DATA = 4'h3;
  localparam logic [3:0] REG_TPTR = 4'h4;
  localparam logic [3:0] REG_TLAT = 4'h5;
  localparam logic [3:0] REG_STAT = 4'h6;
  localparam logic [3:0] REG_MASK = 4'h7;
  localparam int CTRL_RD = 0;
  localparam int CTRL_WR = 1;
  localparam int CTRL_WRITE_ENABLE_BIT = 2;
  localparam int CTRL_PFM = 3;
  localparam int CTRL_ERR = 4;
  localparam int STAT_DONE = 0;
  localparam int STAT_ERR = 1;
  localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
  localparam logic [7:0] UNLOCK_KEY2 = 8'hAA;
  localparam logic [7:0] REG_RST = 8'h00;

  // ----------------------------------------------------------------
  // core end bus map
  // ----------------------------------------------------------------
  localparam logic [7:0] HOFS_CMD = 8'h00;
  localparam logic [7:0] HOFS_RESULT = 8'h04;
  localparam logic [7:0] HOFS_ISTAT = 8'h08;
  localparam logic [7:0] HOFS_IMASK = 8'h0C;
  localparam int CMD_KIND_LSB = 0;
  localparam int CMD_REG_LSB = 4;
  localparam int CMD_DATA_LSB = 8;
  localparam int RES_BUSY_BIT = 8;
  localparam int HIRQ_DONE = 0;
  localparam int HIRQ_DEV = 1;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_RD = 2'h0,
    ACC_WR = 2'h1,
    ACC_TABLE_WRITE_INSTR = 2'h2
  } nvmbw_kind_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FPROG = 3'b010,
    ST_EPROG = 3'b100
  } nvmbw_dstate_t;

  typedef enum logic [2:0] {
    ULK_NONE = 3'b001,
    ULK_HALF = 3'b010,
    ULK_FULL = 3'b100
  } nvmbw_ulk_t;

endpackage

// ### verilog/nvmbw_link_if.sv
// link between the processor core end and the nvm controller
`timescale 1ns/10ps
`default_nettype none
interface nvmbw_link_if;
  import nvmbw_pkg::*;
  logic acc_valid;
  nvmbw_kind_t acc_kind;
  logic [3:0] acc_reg;
  logic [7:0] acc_wdata;
  logic acc_ack;
  logic [7:0] acc_rdata;
  logic cpu_stall;
  logic nvm_irq;

  modport dev (
    input acc_valid, acc_kind, acc_reg, acc_wdata,
    output acc_ack, acc_rdata, cpu_stall, nvm_irq
  );
  modport core (
    output acc_valid, acc_kind, acc_reg, acc_wdata,
    input acc_ack, acc_rdata, cpu_stall, nvm_irq
  );
endinterface
`default_nettype wire

// ### verilog/nvmbw_dev.sv
// nvm block write controller: flash holding latches, eeprom, unlock and timing
`timescale 1ns/10ps
`default_nettype none
module nvmbw_dev #(
  parameter int PROG_CYCLES = nvmbw_pkg::PROG_CYCLES_DFLT,
  parameter int PWRT_CYCLES = nvmbw_pkg::PWRT_CYCLES_DFLT
) (
  input wire logic CLK,
  input wire logic RESET,
  nvmbw_link_if.dev LNK,
  input wire logic CFG_FLASH_WP,
  input wire logic CFG_EE_WP,
  input wire logic CFG_EE_CP,
  output logic PROG_BUSY,
  output logic PWRT_RUNNING
);
  import nvmbw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    nvmbw_dstate_t state;
    nvmbw_ulk_t ulk;
    logic write_enable_bit;
    logic wr;
    logic program_flash;
    logic err;
    logic done;
    logic stat_err;
    logic [1:0] mask;
    logic [7:0] addr;
    logic [7:0] data;
    logic [7:0] tptr;
    logic [7:0] tlat;
    logic [BLK_BYTES-1:0][7:0] latch;
    logic [FLASH_BYTES-1:0][7:0] flash;
    logic [EE_BYTES-1:0][7:0] ee;
    logic [TMR_W-1:0] timer;
    logic [TMR_W-1:0] pwrt;
    logic pwrt_busy;
    logic [2:0] cfg_s1;
    logic [2:0] cfg_s2;
    logic ack;
    logic [7:0] rdata;
    logic stall;
    logic irq;
  } nvmbw_dev_st_t;

  localparam nvmbw_dev_st_t ST_RST = '{
    state: ST_IDLE,
    ulk: ULK_NONE,
    latch: '1,
    flash: '1,
    ee: '1,
    pwrt_busy: 1'b1,
    default: '0
  };
  localparam logic [TMR_W-1:0] PROG_LAST = TMR_W'(PROG_CYCLES - 1);
  localparam logic [TMR_W-1:0] PWRT_END = TMR_W'(PWRT_CYCLES);

  nvmbw_dev_st_t st_r;
  nvmbw_dev_st_t st_nxt;

  logic flash_wp;
  logic ee_wp;
  logic ee_cp;
  assign flash_wp = st_r.cfg_s2[0];
  assign ee_wp = st_r.cfg_s2[1];
  assign ee_cp = st_r.cfg_s2[2];

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic write_enable_bit_new;
    logic pfm_new;
    logic [7:0] rd_mux;
    write_enable_bit_new = 1'b0;
    pfm_new = 1'b0;
    rd_mux = REG_RST;
    st_nxt = st_r;
    st_nxt.ack = 1'b0;
    st_nxt.cfg_s1 = {CFG_EE_CP, CFG_EE_WP, CFG_FLASH_WP};
    st_nxt.cfg_s2 = st_r.cfg_s1;

    // power-up timer, gates eeprom starts
    if (st_r.pwrt != PWRT_END) begin
      st_nxt.pwrt = st_r.pwrt + 1'b1;
    end
    st_nxt.pwrt_busy = (st_nxt.pwrt != PWRT_END);

    case (LNK.acc_reg)
      REG_CTRL: rd_mux = {3'h0, st_r.err, st_r.program_flash, st_r.write_enable_bit, st_r.wr, 1'b0};
      REG_ADDR: rd_mux = st_r.addr;
      REG_DATA: rd_mux = st_r.data;
      REG_TPTR: rd_mux = st_r.tptr;
      REG_TLAT: rd_mux = st_r.tlat;
      REG_STAT: rd_mux = {6'h00, st_r.stat_err, st_r.done};
      REG_MASK: rd_mux = {6'h00, st_r.mask};
      default: rd_mux = REG_RST;
    endcase

    // ----------------------------------------------------------------
    // accesses from the core; none arrive while stalled
    // ----------------------------------------------------------------
    if (LNK.acc_valid && st_r.state != ST_FPROG) begin
      st_nxt.ack = 1'b1;
      st_nxt.ulk = ULK_NONE;
      case (LNK.acc_kind)
        ACC_RD: begin
          st_nxt.rdata = rd_mux;
        end
        ACC_TABLE_WRITE_INSTR: begin
          st_nxt.tlat = LNK.acc_wdata;
          st_nxt.latch[st_r.tptr[BLK_AW-1:0]] = LNK.acc_wdata;
        end
        ACC_WR: begin
          case (LNK.acc_reg)
            REG_UNLOCK: begin
              if (LNK.acc_wdata == UNLOCK_KEY1) begin
                st_nxt.ulk = ULK_HALF;
              end else if (LNK.acc_wdata == UNLOCK_KEY2 && st_r.ulk == ULK_HALF) begin
                st_nxt.ulk = ULK_FULL;
              end
            end
            REG_CTRL: begin
              write_enable_bit_new = LNK.acc_wdata[CTRL_WRITE_ENABLE_BIT];
              pfm_new = LNK.acc_wdata[CTRL_PFM];
              st_nxt.write_enable_bit = write_enable_bit_new;
              if (!st_r.wr) begin
                st_nxt.program_flash = pfm_new;
              end
              st_nxt.err = st_r.err & LNK.acc_wdata[CTRL_ERR];
              if (LNK.acc_wdata[CTRL_RD] && !pfm_new && !st_r.wr) begin
                st_nxt.data = ee_cp ? REG_RST : st_r.ee[st_r.addr];
              end
              if (LNK.acc_wdata[CTRL_WR] && !st_r.wr && st_r.ulk == ULK_FULL && write_enable_bit_new) begin
                if (pfm_new) begin
                  if (flash_wp || st_r.tptr > FLASH_LAST_ADDR) begin
                    st_nxt.err = 1'b1;
                    st_nxt.stat_err = 1'b1;
                  end else begin
                    st_nxt.state = ST_FPROG;
                    st_nxt.wr = 1'b1;
                    st_nxt.stall = 1'b1;
                    st_nxt.timer = '0;
                    st_nxt.ack = 1'b0;
                  end
                end else begin
                  if (ee_cp || ee_wp || st_r.addr > EE_LAST_ADDR || st_r.pwrt_busy) begin
                    st_nxt.err = 1'b1;
                    st_nxt.stat_err = 1'b1;
                  end else begin
                    st_nxt.state = ST_EPROG;
                    st_nxt.wr = 1'b1;
                    st_nxt.timer = '0;
                  end
                end
              end
            end
            REG_ADDR: st_nxt.addr = LNK.acc_wdata;
            REG_DATA: st_nxt.data = LNK.acc_wdata;
            REG_TPTR: st_nxt.tptr = LNK.acc_wdata;
            REG_TLAT: st_nxt.tlat = LNK.acc_wdata;
            REG_STAT: begin
              st_nxt.done = st_r.done & ~LNK.acc_wdata[STAT_DONE];
              st_nxt.stat_err = st_nxt.stat_err & ~LNK.acc_wdata[STAT_ERR];
            end
            REG_MASK: st_nxt.mask = LNK.acc_wdata[1:0];
            default: st_nxt.ulk = ULK_NONE;
          endcase
        end
        default: st_nxt.ulk = ULK_NONE;
      endcase
    end

    // ----------------------------------------------------------------
    // programming sequencer; completion sets done after any clear
    // ----------------------------------------------------------------
    case (st_r.state)
      ST_IDLE: begin
      end
      ST_FPROG: begin
        st_nxt.timer = st_r.timer + 1'b1;
        if (st_r.timer == PROG_LAST) begin
          for (int i = 0; i < BLK_BYTES; i++) begin
            st_nxt.flash[{st_r.tptr[7:BLK_AW], BLK_AW'(i)}] = st_r.latch[i];
          end
          st_nxt.latch = '1;
          st_nxt.wr = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.stall = 1'b0;
          st_nxt.ack = 1'b1;
          st_nxt.state = ST_IDLE;
        end
      end
      ST_EPROG: begin
        st_nxt.timer = st_r.timer + 1'b1;
        if (st_r.timer == PROG_LAST) begin
          st_nxt.ee[st_r.addr] = st_r.data;
          st_nxt.wr = 1'b0;
          st_nxt.done = 1'b1;
          st_nxt.state = ST_IDLE;
        end
      end
      default: st_nxt.state = ST_IDLE;
    endcase

    st_nxt.irq = |({st_nxt.stat_err, st_nxt.done} & st_nxt.mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign LNK.acc_ack = st_r.ack;
  assign LNK.acc_rdata = st_r.rdata;
  assign LNK.cpu_stall = st_r.stall;
  assign LNK.nvm_irq = st_r.irq;
  assign PROG_BUSY = st_r.wr;
  assign PWRT_RUNNING = st_r.pwrt_busy;

endmodule // nvmbw_dev
`default_nettype wire

// ### verilog/nvmbw_core.sv
// core end: ahb-lite command registers driving accesses onto the nvm link
`timescale 1ns/10ps
`default_nettype none
module nvmbw_core (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic HREADYOUT,
  output logic HRESP,
  output logic [31:0] HRDATA,
  output logic IRQ,
  nvmbw_link_if.core LNK
);
  import nvmbw_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic busy;
    logic acc_valid;
    nvmbw_kind_t kind;
    logic [3:0] areg;
    logic [7:0] wdata;
    logic [7:0] result;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
  } nvmbw_core_st_t;

  localparam nvmbw_core_st_t ST_RST = '{kind: ACC_RD, default: '0};

  nvmbw_core_st_t st_r;
  nvmbw_core_st_t st_nxt;
  logic ap_take;
  assign ap_take = HSEL && HREADY && HTRANS[1] && HSIZE == 3'h2;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    st_nxt.acc_valid = 1'b0;
    st_nxt.wr_pend = 1'b0;

    // address phase: latch write target, prepare read data
    if (ap_take) begin
      st_nxt.wr_pend = HWRITE;
      st_nxt.wr_addr = HADDR[7:0];
      case (HADDR[7:0])
        HOFS_RESULT: st_nxt.hrdata = {23'h0, st_r.busy, st_r.result};
        HOFS_ISTAT: st_nxt.hrdata = {30'h0, st_r.istat};
        HOFS_IMASK: st_nxt.hrdata = {30'h0, st_r.imask};
        default: st_nxt.hrdata = 32'h0000_0000;
      endcase
    end

    // data phase: one access per command, issued only when idle
    if (st_r.wr_pend) begin
      case (st_r.wr_addr)
        HOFS_CMD: begin
          if (!st_r.busy) begin
            st_nxt.acc_valid = 1'b1;
            st_nxt.busy = 1'b1;
            st_nxt.kind = nvmbw_kind_t'(HWDATA[CMD_KIND_LSB+:2]);
            st_nxt.areg = HWDATA[CMD_REG_LSB+:4];
            st_nxt.wdata = HWDATA[CMD_DATA_LSB+:8];
          end
        end
        HOFS_ISTAT: st_nxt.istat = st_r.istat & ~HWDATA[1:0];
        HOFS_IMASK: st_nxt.imask = HWDATA[1:0];
        default: st_nxt.busy = st_r.busy;
      endcase
    end

    // answer from the device; flash start answers after programming
    if (LNK.acc_ack) begin
      st_nxt.busy = 1'b0;
      st_nxt.istat[HIRQ_DONE] = 1'b1;
      if (st_r.kind == ACC_RD) begin
        st_nxt.result = LNK.acc_rdata;
      end
    end
    if (LNK.nvm_irq) begin
      st_nxt.istat[HIRQ_DEV] = 1'b1;
    end
    st_nxt.irq = |(st_nxt.istat & st_nxt.imask);
  end

  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      st_r <= ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = st_r.hrdata;
  assign IRQ = st_r.irq;
  assign LNK.acc_valid = st_r.acc_valid;
  assign LNK.acc_kind = st_r.kind;
  assign LNK.acc_reg = st_r.areg;
  assign LNK.acc_wdata = st_r.wdata;

endmodule // nvmbw_core
`default_nettype wire

// ### sim/nvmbw_assertions.sv
// link checks between the core end and the nvm controller
`timescale 1ns/10ps
`default_nettype none
module nvmbw_assertions #(
  parameter int PROG_CYCLES = 8
) (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic acc_valid,
  input wire nvmbw_pkg::nvmbw_kind_t acc_kind,
  input wire logic [3:0] acc_reg,
  input wire logic [7:0] acc_wdata,
  input wire logic acc_ack,
  input wire logic [7:0] acc_rdata,
  input wire logic cpu_stall,
  input wire logic nvm_irq
);
  import nvmbw_pkg::*;
  logic flash_go;
  logic ee_go;
  logic [23:0] stall_cnt_r;
  logic [23:0] stall_cnt_nxt;
  assign ee_go = acc_valid && acc_kind == ACC_WR && acc_reg == REG_CTRL && !acc_wdata[CTRL_PFM];
  assign flash_go = acc_valid && acc_kind == ACC_WR && acc_reg == REG_CTRL && acc_wdata[CTRL_WR] && acc_wdata[CTRL_PFM];
  assign stall_cnt_nxt = cpu_stall ? stall_cnt_r + 24'h1 : 24'h0;
  always_ff @(posedge CLK or posedge RESET) begin
    if (RESET) begin
      stall_cnt_r <= 24'h0;
    end else begin
      stall_cnt_r <= stall_cnt_nxt;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RESET);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ack_quick_a: assert property (acc_valid && !flash_go |=> acc_ack) else $error("no ack after access");
  stall_cause_a: assert property ($rose(cpu_stall) |-> $past(flash_go)) else $error("stray stall");
  stall_len_a: assert property ($fell(cpu_stall) |-> stall_cnt_r == 24'(PROG_CYCLES) && acc_ack)
    else $error("stall length or end ack wrong");
  stall_noack_a: assert property (cpu_stall |-> !acc_ack) else $error("ack during stall");
  ack_pulse_a: assert property (acc_ack |=> !acc_ack) else $error("ack longer than one cycle");
  stall_noreq_a: assert property (cpu_stall |-> !acc_valid) else $error("access during stall");
  latch_quiet_a: assert property (acc_valid && acc_kind == ACC_TABLE_WRITE_INSTR |=> $stable(nvm_irq) [*2])
    else $error("latch load moved irq");
  ee_nostall_a: assert property (ee_go |=> !cpu_stall [*2]) else $error("eeprom start stalled");
  rdata_hold_a: assert property (acc_valid && acc_kind != ACC_RD |=> $stable(acc_rdata))
    else $error("read data moved");
  cover property ($rose(cpu_stall));
  cover property (acc_valid && acc_kind == ACC_TABLE_WRITE_INSTR);
  cover property ($rose(nvm_irq));
endmodule // nvmbw_assertions
`default_nettype wire

// ### sim/tb_top.sv
// self-checking bench: ahb core end and nvm controller joined by the link
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import nvmbw_pkg::*;
  localparam int PROG = 8;
  logic CLK = 1'b0;
  logic RESET = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [2:0] cfg = 3'h0;
  logic hready;
  logic hresp;
  logic irq;
  logic busy;
  logic pwrt;
  logic [31:0] hrdata;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  nvmbw_link_if u_nvmbw_link_if ();
  nvmbw_core u_nvmbw_core (.CLK(CLK), .RESET(RESET), .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRESP(hresp),
    .HRDATA(hrdata), .IRQ(irq), .LNK(u_nvmbw_link_if.core));
  nvmbw_dev #(.PROG_CYCLES(PROG), .PWRT_CYCLES(60)) u_nvmbw_dev (.CLK(CLK), .RESET(RESET),
    .LNK(u_nvmbw_link_if.dev), .CFG_FLASH_WP(cfg[0]), .CFG_EE_WP(cfg[1]), .CFG_EE_CP(cfg[2]),
    .PROG_BUSY(busy), .PWRT_RUNNING(pwrt));
  nvmbw_assertions #(.PROG_CYCLES(PROG)) u_nvmbw_assertions (.CLK(CLK), .RESET(RESET),
    .acc_valid(u_nvmbw_link_if.acc_valid), .acc_kind(u_nvmbw_link_if.acc_kind),
    .acc_reg(u_nvmbw_link_if.acc_reg), .acc_wdata(u_nvmbw_link_if.acc_wdata), .acc_ack(u_nvmbw_link_if.acc_ack),
    .acc_rdata(u_nvmbw_link_if.acc_rdata), .cpu_stall(u_nvmbw_link_if.cpu_stall), .nvm_irq(u_nvmbw_link_if.nvm_irq));
  initial begin
    forever #5 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      print_verdict();
    end
  end
  // ----------------------------------------------------------------
  // bus and compare tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk8({7'h0, got}, {7'h0, exp});
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge CLK);
    while (hready !== 1'b1) @(posedge CLK);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge CLK);
    while (hready !== 1'b1) @(posedge CLK);
    rd = hrdata;
  endtask
  task automatic cmd(input nvmbw_kind_t k, input logic [3:0] r, input logic [7:0] d, output logic [7:0] res);
    logic [31:0] rd;
    ahb(1'b1, HOFS_CMD, {16'h0, d, r, 2'h0, k}, rd);
    do ahb(1'b0, HOFS_RESULT, 32'h0, rd); while (rd[RES_BUSY_BIT] !== 1'b0);
    res = rd[7:0];
  endtask
  task automatic dw(input logic [3:0] r, input logic [7:0] d);
    logic [7:0] x;
    cmd(ACC_WR, r, d, x);
  endtask
  task automatic dr(input logic [3:0] r, output logic [7:0] v);
    cmd(ACC_RD, r, 8'h00, v);
  endtask
  task automatic start(input logic [7:0] c);
    dw(REG_UNLOCK, UNLOCK_KEY1);
    dw(REG_UNLOCK, UNLOCK_KEY2);
    dw(REG_CTRL, c);
  endtask
  task automatic clr();
    dw(REG_STAT, 8'h03);
    dw(REG_CTRL, 8'h00);
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_power();
    logic [7:0] v;
    dr(REG_CTRL, v);
    chk8(v, 8'h00);
    dw(REG_ADDR, 8'h10);
    dw(REG_DATA, 8'h5A);
    start(8'h06);
    chk1(pwrt, 1'b1);
    chk1(busy, 1'b0);
    dr(REG_STAT, v);
    chk8(v, 8'h02);
    clr();
  endtask
  task automatic t_ee();
    logic [7:0] v;
    logic [31:0] rd;
    while (pwrt !== 1'b0) @(posedge CLK);
    dw(REG_CTRL, 8'h01);
    dr(REG_DATA, v);
    chk8(v, ERASED_BYTE);
    dw(REG_MASK, 8'h01);
    dw(REG_DATA, 8'h3C);
    ahb(1'b1, HOFS_IMASK, 32'h2, rd);
    start(8'h06);
    chk1(busy, 1'b1);
    while (busy === 1'b1) @(posedge CLK);
    repeat (3) @(posedge CLK);
    chk1(irq, 1'b1);
    dr(REG_STAT, v);
    chk8(v, 8'h01);
    dw(REG_STAT, 8'h03);
    ahb(1'b1, HOFS_ISTAT, 32'h3, rd);
    ahb(1'b1, HOFS_IMASK, 32'h1, rd);
    repeat (2) @(posedge CLK);
    chk1(irq, 1'b0);
    dw(REG_CTRL, 8'h01);
    dr(REG_DATA, v);
    chk8(v, 8'h3C);
    chk1(irq, 1'b1);
    ahb(1'b1, HOFS_ISTAT, 32'h1, rd);
    ahb(1'b0, 8'h40, 32'h0, rd);
    chk8(rd[7:0], 8'h00);
    chk1(irq, 1'b0);
    dw(REG_MASK, 8'h00);
  endtask
  task automatic t_unlock();
    logic [7:0] v;
    dw(REG_UNLOCK, UNLOCK_KEY1);
    dr(REG_STAT, v);
    dw(REG_UNLOCK, UNLOCK_KEY2);
    dw(REG_CTRL, 8'h06);
    chk1(busy, 1'b0);
    start(8'h02);
    chk1(busy, 1'b0);
    dr(REG_STAT, v);
    chk8(v, 8'h00);
  endtask
  task automatic t_flash();
    logic [7:0] v;
    cfg <= 3'h1;
    for (int i = 0; i < BLK_BYTES; i++) begin
      dw(REG_TPTR, 8'h20 + 8'(i));
      cmd(ACC_TABLE_WRITE_INSTR, REG_TLAT, 8'hA0 + 8'(i), v);
    end
    dr(REG_STAT, v);
    chk8(v, 8'h00);
    cfg <= 3'h0;
    repeat (3) @(posedge CLK);
    start(8'h0E);
    chk1(busy, 1'b0);
    dr(REG_STAT, v);
    chk8(v, 8'h01);
    dr(REG_CTRL, v);
    chk8(v & 8'h06, 8'h04);
    for (int i = 0; i < BLK_BYTES; i++) begin
      chk8(u_nvmbw_dev.st_r.flash[8'h20 + 8'(i)], 8'hA0 + 8'(i));
      chk8(u_nvmbw_dev.st_r.latch[i], ERASED_BYTE);
    end
    clr();
  endtask
  task automatic t_errors();
    logic [7:0] v;
    logic [2:0] cf [5] = '{3'h1, 3'h0, 3'h2, 3'h0, 3'h4};
    logic [7:0] ad [5] = '{8'h20, 8'hF0, 8'h10, 8'hF0, 8'h10};
    logic [7:0] ct [5] = '{8'h0E, 8'h0E, 8'h06, 8'h06, 8'h06};
    dw(REG_DATA, 8'hC3);
    for (int i = 0; i < 5; i++) begin
      cfg <= cf[i];
      dw(REG_TPTR, ad[i]);
      dw(REG_ADDR, ad[i]);
      start(ct[i]);
      chk1(busy, 1'b0);
      dr(REG_STAT, v);
      chk8(v, 8'h02);
      clr();
    end
    dw(REG_CTRL, 8'h01);
    dr(REG_DATA, v);
    chk8(v, 8'h00);
    cfg <= 3'h0;
    dw(REG_ADDR, 8'h10);
    dw(REG_CTRL, 8'h01);
    dr(REG_DATA, v);
    chk8(v, 8'h3C);
  endtask
  task automatic t_reset();
    logic [7:0] v;
    dw(REG_CTRL, 8'h04);
    dr(REG_CTRL, v);
    chk8(v, 8'h04);
    RESET <= 1'b1;
    repeat (4) @(posedge CLK);
    RESET <= 1'b0;
    dr(REG_CTRL, v);
    chk8(v, 8'h00);
    chk1(pwrt, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge CLK);
    RESET <= 1'b0;
    t_power();
    t_ee();
    t_unlock();
    t_flash();
    t_errors();
    t_reset();
    chk1(hresp, 1'b0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
